/* File: hdl/srl_pkg.sv */
package srl_pkg;

	// Bus geometry: partition in the top three bits, block in the top five, word offset below that
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 16;
	localparam int PART_W   = 3;
	localparam int BLK_W    = 5;
	localparam int OFF_W    = 11;
	localparam int NUM_PART = 8;
	localparam int NUM_BLK  = 32;

	// Command codes
	localparam logic [15:0] CMD_READ_ARRAY  = 16'h00ff;
	localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STAT  = 16'h0050;
	localparam logic [15:0] CMD_READ_INFO   = 16'h0090;
	localparam logic [15:0] CMD_QUERY       = 16'h0098;
	localparam logic [15:0] CMD_WORD_PROG   = 16'h0041;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
	localparam logic [15:0] CMD_CONFIRM     = 16'h00d0;
	localparam logic [15:0] CMD_SUSPEND     = 16'h00b0;
	localparam logic [15:0] CMD_LOCK_SETUP  = 16'h0060;
	localparam logic [15:0] CMD_LOCK        = 16'h0001;
	localparam logic [15:0] CMD_LOCKDOWN    = 16'h002f;
	localparam logic [15:0] CMD_OTP_SETUP   = 16'h00c0;

	// Status word bit positions and reset value
	localparam int SR_READY    = 7;
	localparam int SR_ERS_SUSP = 6;
	localparam int SR_ERS_ERR  = 5;
	localparam int SR_PRG_ERR  = 4;
	localparam int SR_VPP_ERR  = 3;
	localparam int SR_PRG_SUSP = 2;
	localparam int SR_LOCK_ERR = 1;
	localparam int SR_OTHER    = 0;
	localparam logic [7:0] SR_RESET = 8'h80;

	// Information space layout
	localparam logic [OFF_W-1:0] INFO_LOCK_OFF = 11'h002;
	localparam int LOCK_STATE_BIT     = 0;
	localparam int LOCKDOWN_STATE_BIT = 1;
	localparam logic [OFF_W-1:0] OTP_BASE = 11'h080;
	localparam int OTP_WORDS = 4;
	localparam logic [DATA_W-1:0] INVALID_DATA = 16'h0000;

	// Timing
	localparam int CLK_NS       = 5;
	localparam int SUSP_LAT_NS  = 100;
	localparam int SUSP_LAT_CYC = (SUSP_LAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC     = 64;
	localparam int ERASE_CYC    = 256;
	localparam int OTP_CYC      = 32;

	typedef enum logic [4:0] {
		CS_IDLE  = 5'h01,
		CS_PROG  = 5'h02,
		CS_ERASE = 5'h04,
		CS_LOCK  = 5'h08,
		CS_OTP   = 5'h10
	} srl_cmdst_e;

	typedef enum logic [3:0] {
		RM_ARRAY  = 4'h1,
		RM_STATUS = 4'h2,
		RM_INFO   = 4'h4,
		RM_QUERY  = 4'h8
	} srl_rmode_e;

endpackage : srl_pkg

/* File: hdl/srl_flash_if.sv */
`timescale 1ns/1ps
interface srl_flash_if import srl_pkg::*; ();
	logic              wrEn;    // Command write strobe
	logic [ADDR_W-1:0] wrAddr;  // Command address
	logic [DATA_W-1:0] wrData;  // Command data
	logic              rdEn;    // Read strobe
	logic [ADDR_W-1:0] rdAddr;  // Read address
	logic [DATA_W-1:0] rdData;  // Read data
	logic              rdValid; // Read data valid
	logic              wpN;     // Write-protect pin, low protects

	modport dev (input wrEn, wrAddr, wrData, rdEn, rdAddr, wpN, output rdData, rdValid);
	modport host (output wrEn, wrAddr, wrData, rdEn, rdAddr, wpN, input rdData, rdValid);
endinterface : srl_flash_if

/* File: hdl/srl_blk_lock.sv */
`timescale 1ns/1ps
module srl_blk_lock (
	input  wire logic sys_clk,   // Clock
	input  wire logic arst_n,    // Async reset
	input  wire logic wpLow,     // Write protect asserted
	input  wire logic lockCmd,   // Lock pulse
	input  wire logic unlockCmd, // Unlock pulse
	input  wire logic lockDnCmd, // Lock-down pulse
	output logic      locked,    // Lock state
	output logic      lockedDn   // Lock-down issued
);
	logic wpPrev_r;

	// Protect edge is seen by comparing with last cycle's level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wpPrev_r <= 1'b0;
		end else begin
			wpPrev_r <= wpLow;
		end
	end

	// Lock bit; protect edge dominates so no lock-down block escapes relock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			locked <= 1'b1;
		end else if (wpLow && !wpPrev_r && lockedDn) begin
			locked <= 1'b1;
		end else if (lockCmd) begin
			locked <= 1'b1;
		end else if (unlockCmd && !(wpLow && lockedDn)) begin
			locked <= 1'b0;
		end
	end

	// Lock-down only records intent; cleared by reset alone
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lockedDn <= 1'b0;
		end else if (lockDnCmd) begin
			lockedDn <= 1'b1;
		end
	end
endmodule : srl_blk_lock

/* File: hdl/srl_flash_dev.sv */
// Behaviour
// - Suspend stops at checkpoint, flags suspended kind
// - Suspended op aborts on protect-pin relock or supply loss
// - Reset aborts any suspended operation
// - Only listed commands accepted while suspended
// - Program into erase-suspended block sets error
// - Program under erase suspend may suspend
// - Resume continues operation, keeps read mode
// - Double suspend: resume program first, erase next
// - Host never reads suspended block
// - Busy partition serves status only
// - OTP program blocks info and query reads
// - OTP space maps onto addressed partition
// - Reset locks all blocks, clears lock-down
// - Locking ignores program supply level
// - Lock setup then lock or lock-down confirm
// - Lock setup then confirm code unlocks
// - Lock setup switches partition to status
// - Info offset two returns lock bits
// - No lock change on busy block, program suspend
// - Locking erase-suspended block keeps erase resumable
// - Protect pin holds and relocks lock-down blocks
// - Lock-down on unlocked block waits for pin
// - Single-cycle suspend and resume at any address
`timescale 1ns/1ps
module srl_flash_dev import srl_pkg::*; #(
	parameter int PROG_CYCLES  = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int OTP_CYCLES   = OTP_CYC
) (
	input  wire logic              sys_clk,   // Clock
	input  wire logic              arst_n,    // Async reset
	srl_flash_if.dev               link,      // Flash bus
	input  wire logic              vppOk,     // Program supply valid
	input  wire logic [DATA_W-1:0] arrData,   // Array core read data
	output logic      [ADDR_W-1:0] arrAddr,   // Array core read address
	output logic      [7:0]        statusOut  // Status word copy
);
	srl_cmdst_e        cmdSt_r;
	srl_rmode_e        rmode_r [NUM_PART];
	logic              ersAct_r, ersRun_r, prgAct_r, prgRun_r, otpRun_r;
	logic [BLK_W-1:0]  ersBlk_r, prgBlk_r;
	logic [PART_W-1:0] otpPart_r;
	logic [15:0]       ersCnt_r, prgCnt_r, otpCnt_r, suspCnt_r;
	logic              suspPend_r, suspLocked_r;
	logic              ersErr_r, prgErr_r, vppErr_r, lockErr_r;
	logic [DATA_W-1:0] otpMem_r [OTP_WORDS];
	logic [DATA_W-1:0] rdData_r;
	logic              rdValid_r;
	logic [NUM_BLK-1:0] locked, lockedDn, lockPls, unlockPls, lockDnPls;
	logic [NUM_PART-1:0] partBusy;

	logic [PART_W-1:0] wrPart, rdPart;
	logic [BLK_W-1:0]  wrBlk, rdBlk;
	logic [OFF_W-1:0]  wrOff, rdOff;
	logic ersSusp, prgSusp, ready, abortSusp;
	logic startPrg, startErs, startOtp, reqSusp, resumePrg, resumeErs, clrErr;
	logic setPrgErr, setErsErr, setVppErr, setLockErr, lockOk, modeWr, suspLockHit;
	srl_rmode_e modeNxt;
	srl_cmdst_e cmdSt_nxt;
	logic [7:0] sr;

	assign wrPart  = link.wrAddr[ADDR_W-1 -: PART_W];
	assign wrBlk   = link.wrAddr[ADDR_W-1 -: BLK_W];
	assign wrOff   = link.wrAddr[OFF_W-1:0];
	assign rdPart  = link.rdAddr[ADDR_W-1 -: PART_W];
	assign rdBlk   = link.rdAddr[ADDR_W-1 -: BLK_W];
	assign rdOff   = link.rdAddr[OFF_W-1:0];
	assign arrAddr = link.rdAddr;
	assign ersSusp = ersAct_r && !ersRun_r;
	assign prgSusp = prgAct_r && !prgRun_r;
	assign ready   = !(ersRun_r || prgRun_r || otpRun_r);

	// Supply loss or a hardware relock of the target kills the suspended work
	assign abortSusp = (ersSusp || prgSusp) && (!vppOk
		|| (ersSusp && locked[ersBlk_r] && !suspLocked_r)
		|| (prgSusp && locked[prgBlk_r]));

	// Lock changes refused on a block under way and in program suspend
	assign lockOk = !prgSusp && !(prgRun_r && wrBlk == prgBlk_r)
		&& !(ersRun_r && wrBlk == ersBlk_r);

	// Command decode: one cycle of a two-cycle sequence per write strobe
	always_comb begin
		cmdSt_nxt = cmdSt_r;
		{startPrg, startErs, startOtp, reqSusp, resumePrg, resumeErs} = '0;
		{clrErr, setPrgErr, setErsErr, setVppErr, setLockErr, modeWr} = '0;
		suspLockHit = 1'b0;
		modeNxt = RM_STATUS;
		lockPls = '0;
		unlockPls = '0;
		lockDnPls = '0;
		if (link.wrEn) begin
			unique case (cmdSt_r)
				CS_IDLE: begin
					unique case (link.wrData)
						CMD_READ_ARRAY:  begin modeWr = 1'b1; modeNxt = RM_ARRAY;  end
						CMD_READ_STATUS: begin modeWr = 1'b1; modeNxt = RM_STATUS; end
						CMD_READ_INFO:   begin modeWr = 1'b1; modeNxt = RM_INFO;   end
						CMD_QUERY:       begin modeWr = 1'b1; modeNxt = RM_QUERY;  end
						CMD_CLEAR_STAT:  clrErr = 1'b1;
						CMD_WORD_PROG: begin
							// Program only when free or under erase suspend
							if (!prgAct_r && !ersRun_r && !otpRun_r) begin
								cmdSt_nxt = CS_PROG;
								modeWr = 1'b1;
							end
						end
						CMD_ERASE_SETUP: begin
							if (!ersAct_r && !prgAct_r && !otpRun_r) begin
								cmdSt_nxt = CS_ERASE;
								modeWr = 1'b1;
							end
						end
						CMD_SUSPEND: reqSusp = (prgRun_r || ersRun_r) && !suspPend_r;
						CMD_CONFIRM: begin
							resumePrg = prgSusp;
							resumeErs = ersSusp && !prgAct_r;
						end
						CMD_LOCK_SETUP: begin
							cmdSt_nxt = CS_LOCK;
							modeWr = 1'b1;
						end
						CMD_OTP_SETUP: begin
							if (!ersAct_r && !prgAct_r && !otpRun_r) begin
								cmdSt_nxt = CS_OTP;
							end
						end
						default: ;
					endcase
				end
				CS_PROG: begin
					cmdSt_nxt = CS_IDLE;
					if (ersSusp && wrBlk == ersBlk_r) begin
						setPrgErr = 1'b1;
					end else if (locked[wrBlk]) begin
						{setPrgErr, setLockErr} = 2'b11;
					end else if (!vppOk) begin
						{setPrgErr, setVppErr} = 2'b11;
					end else begin
						startPrg = 1'b1;
					end
				end
				CS_ERASE: begin
					cmdSt_nxt = CS_IDLE;
					if (link.wrData != CMD_CONFIRM) begin
						{setPrgErr, setErsErr} = 2'b11;
					end else if (locked[wrBlk]) begin
						{setErsErr, setLockErr} = 2'b11;
					end else if (!vppOk) begin
						{setErsErr, setVppErr} = 2'b11;
					end else begin
						startErs = 1'b1;
					end
				end
				CS_LOCK: begin
					// Supply level is not consulted here
					cmdSt_nxt = CS_IDLE;
					if (!lockOk) begin
						setLockErr = 1'b1;
					end else begin
						lockPls[wrBlk]   = (link.wrData == CMD_LOCK);
						lockDnPls[wrBlk] = (link.wrData == CMD_LOCKDOWN);
						unlockPls[wrBlk] = (link.wrData == CMD_CONFIRM);
						suspLockHit = ersSusp && wrBlk == ersBlk_r;
					end
				end
				CS_OTP: begin
					cmdSt_nxt = CS_IDLE;
					if (wrPart == otpPart_r && wrOff >= OTP_BASE
						&& wrOff < OTP_BASE + OFF_W'(OTP_WORDS)) begin
						startOtp = 1'b1;
					end else begin
						setPrgErr = 1'b1;
					end
				end
				default: cmdSt_nxt = CS_IDLE;
			endcase
		end
	end

	// Sequence state
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmdSt_r <= CS_IDLE;
		end else begin
			cmdSt_r <= cmdSt_nxt;
		end
	end

	// Per-partition read mode; suspend and resume leave it alone
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < NUM_PART; p++) begin
				rmode_r[p] <= RM_ARRAY;
			end
		end else if (modeWr) begin
			rmode_r[wrPart] <= modeNxt;
		end
	end

	// Operations: reset drops everything, array content left undefined
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{ersAct_r, ersRun_r, prgAct_r, prgRun_r, otpRun_r} <= '0;
			{suspPend_r, suspLocked_r} <= '0;
			ersBlk_r <= '0;
			prgBlk_r <= '0;
			otpPart_r <= '0;
			{ersCnt_r, prgCnt_r, otpCnt_r, suspCnt_r} <= '0;
		end else if (abortSusp) begin
			{ersAct_r, ersRun_r, prgAct_r, prgRun_r, suspLocked_r} <= '0;
		end else begin
			if (startErs) begin
				{ersAct_r, ersRun_r, suspLocked_r} <= 3'b110;
				ersBlk_r <= wrBlk;
				ersCnt_r <= 16'(ERASE_CYCLES);
			end else if (ersRun_r && !prgRun_r) begin
				if (ersCnt_r == 16'h0001) begin
					{ersAct_r, ersRun_r} <= 2'b00;
				end
				ersCnt_r <= ersCnt_r - 16'h0001;
			end
			if (startPrg) begin
				{prgAct_r, prgRun_r} <= 2'b11;
				prgBlk_r <= wrBlk;
				prgCnt_r <= 16'(PROG_CYCLES);
			end else if (prgRun_r) begin
				if (prgCnt_r == 16'h0001) begin
					{prgAct_r, prgRun_r} <= 2'b00;
				end
				prgCnt_r <= prgCnt_r - 16'h0001;
			end
			if (startOtp) begin
				otpRun_r <= 1'b1;
				otpCnt_r <= 16'(OTP_CYCLES);
			end else if (otpRun_r) begin
				if (otpCnt_r == 16'h0001) begin
					otpRun_r <= 1'b0;
				end
				otpCnt_r <= otpCnt_r - 16'h0001;
			end
			if (cmdSt_r == CS_IDLE && link.wrEn && link.wrData == CMD_OTP_SETUP) begin
				otpPart_r <= wrPart;
			end
			if (suspLockHit) begin
				suspLocked_r <= 1'b1;
			end
			// Work runs on until the checkpoint, then the inner job parks
			if (reqSusp) begin
				suspPend_r <= 1'b1;
				suspCnt_r <= 16'(SUSP_LAT_CYC);
			end else if (suspPend_r) begin
				suspCnt_r <= suspCnt_r - 16'h0001;
				if (!prgRun_r && !ersRun_r) begin
					suspPend_r <= 1'b0;
				end else if (suspCnt_r == 16'h0001) begin
					suspPend_r <= 1'b0;
					if (prgRun_r) begin
						prgRun_r <= 1'b0;
					end else begin
						ersRun_r <= 1'b0;
					end
				end
			end
			if (resumePrg) begin
				prgRun_r <= 1'b1;
			end else if (resumeErs) begin
				ersRun_r <= 1'b1;
			end
		end
	end

	// One-time words only ever lose ones
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < OTP_WORDS; i++) begin
				otpMem_r[i] <= 16'hffff;
			end
		end else if (startOtp) begin
			otpMem_r[2'(wrOff - OTP_BASE)] <= otpMem_r[2'(wrOff - OTP_BASE)] & link.wrData;
		end
	end

	// Error flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{ersErr_r, prgErr_r, vppErr_r, lockErr_r} <= '0;
		end else begin
			if (clrErr) begin
				{ersErr_r, prgErr_r, vppErr_r, lockErr_r} <= '0;
			end
			if (setErsErr || (abortSusp && ersAct_r)) ersErr_r <= 1'b1;
			if (setPrgErr || (abortSusp && prgAct_r)) prgErr_r <= 1'b1;
			if (setVppErr || (abortSusp && !vppOk)) vppErr_r <= 1'b1;
			if (setLockErr || (abortSusp && vppOk)) lockErr_r <= 1'b1;
		end
	end

	// Which partitions hold work that is running
	always_comb begin
		for (int p = 0; p < NUM_PART; p++) begin
			partBusy[p] = (prgRun_r && prgBlk_r[BLK_W-1 -: PART_W] == PART_W'(p))
				|| (ersRun_r && ersBlk_r[BLK_W-1 -: PART_W] == PART_W'(p))
				|| (otpRun_r && otpPart_r == PART_W'(p));
		end
	end

	assign sr = {ready, ersSusp, ersErr_r, prgErr_r, vppErr_r, prgSusp, lockErr_r, 1'b0};

	// Read path, one cycle latency; busy partition gives status only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= '0;
			rdValid_r <= 1'b0;
			statusOut <= SR_RESET;
		end else begin
			rdValid_r <= link.rdEn;
			statusOut <= sr;
			if (link.rdEn) begin
				unique case (rmode_r[rdPart])
					RM_STATUS: rdData_r <= {8'h00, sr[7:1], !ready && !partBusy[rdPart]};
					RM_ARRAY:  rdData_r <= partBusy[rdPart] ? INVALID_DATA : arrData;
					RM_INFO: begin
						if (partBusy[rdPart] || otpRun_r) begin
							rdData_r <= INVALID_DATA;
						end else if (rdOff == INFO_LOCK_OFF) begin
							rdData_r <= INVALID_DATA;
							rdData_r[LOCK_STATE_BIT] <= locked[rdBlk];
							rdData_r[LOCKDOWN_STATE_BIT] <= lockedDn[rdBlk];
						end else if (rdPart == otpPart_r && rdOff >= OTP_BASE
							&& rdOff < OTP_BASE + OFF_W'(OTP_WORDS)) begin
							rdData_r <= otpMem_r[2'(rdOff - OTP_BASE)];
						end else begin
							rdData_r <= INVALID_DATA;
						end
					end
					RM_QUERY: rdData_r <= INVALID_DATA;
				endcase
			end
		end
	end

	assign link.rdData  = rdData_r;
	assign link.rdValid = rdValid_r;

	// One lock cell per block
	for (genvar b = 0; b < NUM_BLK; b++) begin : gLock
		srl_blk_lock uLock (
			.sys_clk   (sys_clk),
			.arst_n    (arst_n),
			.wpLow     (!link.wpN),
			.lockCmd   (lockPls[b]),
			.unlockCmd (unlockPls[b]),
			.lockDnCmd (lockDnPls[b]),
			.locked    (locked[b]),
			.lockedDn  (lockedDn[b])
		);
	end
endmodule : srl_flash_dev

/* File: hdl/srl_flash_host.sv */
`timescale 1ns/1ps
module srl_flash_host import srl_pkg::*; (
	input  wire logic              sys_clk,  // Clock
	input  wire logic              arst_n,   // Async reset
	srl_flash_if.host              link,     // Flash bus
	input  wire logic              reqValid, // Request present
	input  wire logic              reqWrite, // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] reqAddr,  // Request address
	input  wire logic [DATA_W-1:0] reqData,  // Write data
	output logic                   reqReady, // Request taken
	output logic                   rspValid, // Read answer pulse
	output logic      [DATA_W-1:0] rspData,  // Read data
	output logic                   rspErr,   // Read refused
	input  wire logic              wpReqN    // Wanted protect level
);
	typedef enum logic [1:0] {H_IDLE = 2'b01, H_RD = 2'b10} srl_hst_e;

	srl_hst_e          st_r;
	logic              wrEn_r, rdEn_r, wpN_r, second_r;
	logic [ADDR_W-1:0] wrAddr_r, rdAddr_r;
	logic [DATA_W-1:0] wrData_r;
	logic [1:0]        suspCnt_r;
	logic [BLK_W-1:0]  ersBlk_r, prgBlk_r, blk;
	logic [15:0]       setup_r;
	logic              take, isWr, isRd, hitSusp;

	assign reqReady = (st_r == H_IDLE);
	assign take     = reqValid && reqReady;
	assign isWr     = take && reqWrite;
	assign blk      = reqAddr[ADDR_W-1 -: BLK_W];
	assign hitSusp  = suspCnt_r != 2'd0 && (blk == ersBlk_r || blk == prgBlk_r);
	assign isRd     = take && !reqWrite && !hitSusp;

	// Bus strobes, one cycle each
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{wrEn_r, rdEn_r} <= 2'b00;
			wrAddr_r <= '0;
			wrData_r <= '0;
			rdAddr_r <= '0;
		end else begin
			wrEn_r <= isWr;
			rdEn_r <= isRd;
			if (isWr) begin
				wrAddr_r <= reqAddr;
				wrData_r <= reqData;
			end
			if (isRd) begin
				rdAddr_r <= reqAddr;
			end
		end
	end

	// Track command cycles so suspended state is known on this side
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			second_r <= 1'b0;
			setup_r <= '0;
			suspCnt_r <= '0;
			ersBlk_r <= '0;
			prgBlk_r <= '0;
		end else if (isWr) begin
			if (second_r) begin
				second_r <= 1'b0;
				if (setup_r == CMD_WORD_PROG) prgBlk_r <= blk;
				if (setup_r == CMD_ERASE_SETUP) ersBlk_r <= blk;
			end else begin
				setup_r <= reqData;
				second_r <= reqData == CMD_WORD_PROG || reqData == CMD_ERASE_SETUP
					|| reqData == CMD_LOCK_SETUP || reqData == CMD_OTP_SETUP;
				if (reqData == CMD_SUSPEND && suspCnt_r != 2'd2) begin
					suspCnt_r <= suspCnt_r + 2'd1;
				end
				// Each resume releases one level; reads to both tracked blocks stay refused until no level is left
				if (reqData == CMD_CONFIRM && suspCnt_r != 2'd0) begin
					suspCnt_r <= suspCnt_r - 2'd1;
				end
			end
		end
	end

	// Protect pin follows request only while nothing is suspended
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wpN_r <= 1'b0;
		end else if (suspCnt_r == 2'd0) begin
			wpN_r <= wpReqN;
		end
	end

	// Read answer; refused reads answer at once with the error flag
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= H_IDLE;
			rspValid <= 1'b0;
			rspErr <= 1'b0;
			rspData <= '0;
		end else begin
			rspValid <= 1'b0;
			unique case (st_r)
				H_IDLE: begin
					if (take && !reqWrite && hitSusp) begin
						rspValid <= 1'b1;
						rspErr <= 1'b1;
					end else if (isRd) begin
						st_r <= H_RD;
					end
				end
				H_RD: begin
					if (link.rdValid) begin
						rspValid <= 1'b1;
						rspErr <= 1'b0;
						rspData <= link.rdData;
						st_r <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign link.wrEn   = wrEn_r;
	assign link.wrAddr = wrAddr_r;
	assign link.wrData = wrData_r;
	assign link.rdEn   = rdEn_r;
	assign link.rdAddr = rdAddr_r;
	assign link.wpN    = wpN_r;
endmodule : srl_flash_host

/* File: test/srl_flash_chk.sv */
`timescale 1ns/1ps
module srl_flash_chk import srl_pkg::*; (
	input wire logic              sys_clk, // Clock
	input wire logic              arst_n,  // Reset
	input wire logic              wrEn,    // Write strobe
	input wire logic [ADDR_W-1:0] wrAddr,  // Write address
	input wire logic [DATA_W-1:0] wrData,  // Write data
	input wire logic              rdEn,    // Read strobe
	input wire logic [ADDR_W-1:0] rdAddr,  // Read address
	input wire logic [DATA_W-1:0] rdData,  // Read data
	input wire logic              rdValid, // Read valid
	input wire logic              wpN      // Protect pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Lock setup, confirm, info mode on that partition, then a read of its lock word
	sequence lkRd(logic [15:0] cfm);
		wrEn && wrData == CMD_LOCK_SETUP
		##1 wrEn && wrData == cfm && wrAddr[15:11] == $past(wrAddr[15:11])
		##1 wrEn && wrData == CMD_READ_INFO && wrAddr[15:13] == $past(wrAddr[15:13])
		##1 rdEn && rdAddr == {$past(wrAddr[15:11], 2), INFO_LOCK_OFF};
	endsequence
	// Read handshake and lock word relations on the link
	rd_answer_a: assert property (rdEn |=> rdValid)
		else $error("read not answered");
	no_stray_a: assert property (!rdEn |=> !rdValid)
		else $error("read valid without read");
	rd_spacing_a: assert property (rdEn |=> !rdEn [*2])
		else $error("reads too close");
	data_hold_a: assert property (!rdValid |-> $stable(rdData))
		else $error("read data moved");
	reset_idle_a: assert property ($rose(arst_n) |-> !wpN && !rdValid && !wrEn && !rdEn)
		else $error("link not idle after reset");
	lock_set_a: assert property (lkRd(CMD_LOCK) |=> rdData[LOCK_STATE_BIT])
		else $error("lock not shown");
	unlock_clr_a: assert property (lkRd(CMD_CONFIRM) ##0 wpN |=> !rdData[LOCK_STATE_BIT])
		else $error("unlock not shown");
	down_mark_a: assert property (lkRd(CMD_LOCKDOWN) |=> rdData[LOCKDOWN_STATE_BIT])
		else $error("lock-down not recorded");
	cover property (wrEn && wrData == CMD_SUSPEND);
	cover property ($fell(wpN));
	cover property (lkRd(CMD_LOCKDOWN));
endmodule : srl_flash_chk

/* File: test/suspend_resume_block_lock_control_tb.sv */
`timescale 1ns/1ps
module suspend_resume_block_lock_control_tb import srl_pkg::*; ();
	localparam logic [15:0] ERS = 16'h2000; // Erased block; status read via 2800h
	localparam logic [15:0] PRG = 16'h6000; // Programmed block; status via 6800h
	logic              sys_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              reqValid = 1'b0;
	logic              reqWrite = 1'b0;
	logic              wpReqN = 1'b0;
	logic              vppOk = 1'b1;
	logic              reqReady, rspValid, rspErr;
	logic [ADDR_W-1:0] reqAddr = 16'h0000;
	logic [DATA_W-1:0] reqData = 16'h0000;
	logic [ADDR_W-1:0] arrAddr, blk;
	logic [DATA_W-1:0] rspData, arrData;
	logic [7:0]        statusOut;
	logic [31:0]       lfsr = 32'h40332730;
	logic [3:0]        dn = 4'h0;
	logic              errExp = 1'b0;
	int                miscompares = 0;
	int                total_checks = 0;
	int                cycles = 0;
	srl_flash_if i_srl_flash_if ();
	srl_flash_dev i_srl_flash_dev (.sys_clk, .arst_n, .link(i_srl_flash_if), .vppOk,
		.arrData, .arrAddr, .statusOut);
	srl_flash_host i_srl_flash_host (.sys_clk, .arst_n, .link(i_srl_flash_if), .reqValid,
		.reqWrite, .reqAddr, .reqData, .reqReady, .rspValid, .rspData, .rspErr, .wpReqN);
	srl_flash_chk i_srl_flash_chk (.sys_clk, .arst_n, .wrEn(i_srl_flash_if.wrEn),
		.wrAddr(i_srl_flash_if.wrAddr), .wrData(i_srl_flash_if.wrData),
		.rdEn(i_srl_flash_if.rdEn), .rdAddr(i_srl_flash_if.rdAddr),
		.rdData(i_srl_flash_if.rdData), .rdValid(i_srl_flash_if.rdValid),
		.wpN(i_srl_flash_if.wpN));
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [15:0] arrExp(logic [15:0] a);
		return a ^ 16'h5a5a;
	endfunction : arrExp
	function automatic logic [15:0] lw(logic l, logic d);
		return {14'h0000, d, l};
	endfunction : lw
	// Array core stand-in: data follows address so a stale word is caught
	assign arrData = arrExp(arrAddr);
	always #2.5 sys_clk = ~sys_clk;
	// Hang guard, well past the erase time
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// Request held until the host takes it
	task automatic req(logic w, logic [15:0] a, logic [15:0] d);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		do @(posedge sys_clk); while (reqReady !== 1'b1);
	endtask : req
	task automatic rd(string n, logic [15:0] a, logic [15:0] e);
		req(1'b0, a, 16'h0000);
		reqValid <= 1'b0;
		do @(posedge sys_clk); while (rspValid !== 1'b1);
		chk(n, rspData, e);
		chk("rsp err", {15'h0000, rspErr}, {15'h0000, errExp});
	endtask : rd
	task automatic gap(int n);
		reqValid <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : gap
	task automatic lk(logic [15:0] a, logic [15:0] c, logic [15:0] e);
		req(1'b1, a, CMD_LOCK_SETUP);
		req(1'b1, a, c);
		req(1'b1, a, CMD_READ_INFO);
		rd("lock word", {a[15:11], INFO_LOCK_OFF}, e);
	endtask : lk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	// Main sequence: locking, then erase and program suspend
	initial begin
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		wpReqN <= 1'b1;
		req(1'b1, 16'h1000, CMD_READ_INFO);
		rd("reset lock", 16'h1002, lw(1'b1, 1'b0));
		for (int i = 0; i < 3; i++) begin
			lfsr = nxt(lfsr);
			blk = {3'h0, lfsr[1:0], 11'h000};
			lk(blk, CMD_CONFIRM, lw(1'b0, dn[lfsr[1:0]]));
			lk(blk, CMD_LOCK, lw(1'b1, dn[lfsr[1:0]]));
			lk(blk, CMD_CONFIRM, lw(1'b0, dn[lfsr[1:0]]));
			lk(blk, CMD_LOCKDOWN, lw(1'b0, 1'b1));
			dn[lfsr[1:0]] = 1'b1;
		end
		wpReqN <= 1'b0;
		gap(4);
		req(1'b1, blk, CMD_READ_INFO);
		rd("relock", {blk[15:11], INFO_LOCK_OFF}, lw(1'b1, 1'b1));
		req(1'b1, blk, CMD_LOCK_SETUP);
		req(1'b1, blk, CMD_CONFIRM);
		rd("unlock refused", blk, 16'h0080);
		req(1'b1, blk, CMD_READ_INFO);
		rd("still locked", {blk[15:11], INFO_LOCK_OFF}, lw(1'b1, 1'b1));
		req(1'b1, blk, CMD_CLEAR_STAT);
		vppOk <= 1'b0;
		lk(ERS, CMD_CONFIRM, lw(1'b0, 1'b0));
		vppOk <= 1'b1;
		// One-time word programs on partition 4, kept clear of the array reads below
		req(1'b1, 16'h8000, CMD_OTP_SETUP);
		req(1'b1, 16'h8080, 16'h1234);
		req(1'b1, 16'h8000, CMD_READ_INFO);
		rd("otp busy", 16'h8080, INVALID_DATA);
		gap(OTP_CYC);
		rd("otp word", 16'h8080, 16'h1234);
		$display("lock test done");
		req(1'b1, ERS, CMD_ERASE_SETUP);
		req(1'b1, ERS, CMD_CONFIRM);
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			rd("rww array", {3'h2, lfsr[12:0]}, arrExp({3'h2, lfsr[12:0]}));
		end
		req(1'b1, 16'h2800, CMD_READ_ARRAY);
		rd("busy part", 16'h2804, INVALID_DATA);
		req(1'b1, 16'h2800, CMD_READ_STATUS);
		req(1'b1, 16'h0000, CMD_SUSPEND);
		gap(SUSP_LAT_CYC + 2);
		rd("erase susp", 16'h2800, 16'h00c0);
		req(1'b1, ERS | 16'h0010, CMD_WORD_PROG);
		req(1'b1, ERS | 16'h0010, 16'h1234);
		rd("prog susp blk", 16'h2800, 16'h00d0);
		req(1'b1, 16'h2800, CMD_CLEAR_STAT);
		req(1'b1, ERS, CMD_LOCK_SETUP);
		req(1'b1, ERS, CMD_LOCK);
		lk(PRG, CMD_CONFIRM, lw(1'b0, 1'b0));
		req(1'b1, PRG, CMD_WORD_PROG);
		req(1'b1, PRG, 16'h1234);
		req(1'b1, 16'h0000, CMD_SUSPEND);
		gap(SUSP_LAT_CYC + 2);
		rd("both susp", 16'h6800, 16'h00c4);
		errExp = 1'b1;
		rd("refused rd", ERS, 16'h00c4);
		errExp = 1'b0;
		req(1'b1, 16'h0000, CMD_CONFIRM);
		gap(4);
		rd("prog resumed", 16'h6800, 16'h0040);
		gap(PROG_CYC);
		rd("prog done", 16'h6800, 16'h00c0);
		req(1'b1, 16'h0000, CMD_CONFIRM);
		gap(4);
		rd("erase resumed", 16'h2800, 16'h0000);
		gap(ERASE_CYC);
		rd("erase done", 16'h2800, 16'h0080);
		chk("status out", {8'h00, statusOut}, 16'h0080);
		req(1'b1, ERS, CMD_READ_INFO);
		rd("ers locked", ERS | 16'h0002, lw(1'b1, 1'b0));
		$display("suspend test done");
		print_verdict();
	end
endmodule : suspend_resume_block_lock_control_tb
